// ### hdl/fces_seq.sv
// Whole-array erase, suspend and resume command sequencer of a serial flash
// Functional notes
// - Opcodes C7h and 60h both start a whole-array erase, handled identically.
// - Completed whole-array erase fills every array byte with FFh.
// - Whole-array erase accepted only with the write enable latch set.
// - Chip select must rise right after the eighth bit, else no whole-array erase.
// - Chip select rise after a valid erase opcode starts the timed erase.
// - Status stays readable; write in progress is one while busy, zero after.
// - Finished whole-array erase clears the write enable latch.
// - Whole-array erase runs only with all protect bits zero.
// - Suspend honoured during sector or block erase, ignored during whole-array erase.
// - Erase suspended: reads and programs of other sectors allowed.
// - Erase suspended: status write and every erase opcode refused.
// - Suspend interrupts a running page program; then reads and erases allowed.
// - Program suspended: status write and all three page program opcodes refused.
// - Resume accepted only with suspend flag one and write in progress zero.
// - Accepted resume clears suspend at once, sets busy within 200 ns.
// - Resume ignored when suspend flag zero or write in progress one.
`timescale 1ns/1ps
`include "fces_regs.svh"

module fces_seq #(
    parameter logic [31:0] CE_CYCLES   = `FCES_CE_CYC,
    parameter logic [31:0] PP_CYCLES   = `FCES_PP_CYC,
    parameter logic [31:0] SE_CYCLES   = `FCES_SE_CYC,
    parameter logic [31:0] BE32_CYCLES = `FCES_BE32_CYC,
    parameter logic [31:0] BE64_CYCLES = `FCES_BE64_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               si,
    output logic                    so_out,
    output logic                    so_oe,
    input  wire logic               protect_bit_0,
    input  wire logic               protect_bit_1,
    input  wire logic               protect_bit_2,
    output fces_pkg::fces_status_t  status,
    output fces_pkg::fces_cmd_t     cmd_accept,
    output logic                    array_fill,
    output logic [7:0]              array_fill_byte
);

    function automatic logic is_ce(input logic [7:0] op);
        is_ce = (op == `FCES_OP_CE_A) || (op == `FCES_OP_CE_B);
    endfunction : is_ce

    function automatic logic is_erase(input logic [7:0] op);
        is_erase = is_ce(op) || (op == `FCES_OP_SE) || (op == `FCES_OP_BE32)
                   || (op == `FCES_OP_BE64) || (op == `FCES_OP_SECR_ER);
    endfunction : is_erase

    function automatic logic is_prog(input logic [7:0] op);
        is_prog = (op == `FCES_OP_PP) || (op == `FCES_OP_PP_ALT) || (op == `FCES_OP_QPP);
    endfunction : is_prog

    // ----------------------------------------------------------------
    // Link side, clocked by the host serial clock
    // ----------------------------------------------------------------
    logic [3:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] op_link_q;
    logic       byte_tgl_q;
    logic       over_tgl_q;
    logic [7:0] stat_l1_q;
    logic [7:0] stat_l2_q;
    logic [7:0] so_sr_q;
    logic       rd_q;
    logic [7:0] stat_byte;
    logic [2:0] bp;

    assign bp = {protect_bit_2, protect_bit_1, protect_bit_0};

    // Frame-scoped state is cleared by chip select itself, since the link clock stops
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 4'h0;
            shift_q   <= 7'h00;
        end else begin
            shift_q <= {shift_q[5:0], si};
            if (bit_cnt_q != 4'h9) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    // Toggles survive between frames; data word is held until the next eighth bit
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            op_link_q  <= 8'h00;
            byte_tgl_q <= 1'b0;
            over_tgl_q <= 1'b0;
        end else if (!cs_n) begin
            if (bit_cnt_q == 4'h7) begin
                op_link_q  <= {shift_q, si};
                byte_tgl_q <= ~byte_tgl_q;
            end
            if (bit_cnt_q == 4'h8) begin
                over_tgl_q <= ~over_tgl_q;
            end
        end
    end

    // Status bits crossed per bit; they move slowly relative to a status read
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            stat_l1_q <= `FCES_SR_RESET;
            stat_l2_q <= `FCES_SR_RESET;
        end else begin
            stat_l1_q <= stat_byte;
            stat_l2_q <= stat_l1_q;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rd_q    <= 1'b0;
            so_sr_q <= 8'h00;
        end else if (bit_cnt_q == 4'h7 && {shift_q, si} == `FCES_OP_RDSR) begin
            rd_q    <= 1'b1;
            so_sr_q <= stat_l2_q;
        end else if (rd_q) begin
            so_sr_q <= {so_sr_q[6:0], so_sr_q[7]};
        end
    end

    always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
        if (rst || cs_n) begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
        end else begin
            so_out <= so_sr_q[7];
            so_oe  <= rd_q;
        end
    end

    // ----------------------------------------------------------------
    // Crossing into the system clock
    // ----------------------------------------------------------------
    logic [2:0] csn_s_q;
    logic [2:0] byte_s_q;
    logic [2:0] over_s_q;
    logic       byte_evt;
    logic       over_evt;
    logic       cs_rise;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csn_s_q  <= 3'b111;
            byte_s_q <= 3'b000;
            over_s_q <= 3'b000;
        end else begin
            csn_s_q  <= {csn_s_q[1:0], cs_n};
            byte_s_q <= {byte_s_q[1:0], byte_tgl_q};
            over_s_q <= {over_s_q[1:0], over_tgl_q};
        end
    end

    assign byte_evt = byte_s_q[2] ^ byte_s_q[1];
    assign over_evt = over_s_q[2] ^ over_s_q[1];
    assign cs_rise  = csn_s_q[1] & ~csn_s_q[2];

    logic got_q;
    logic over_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            got_q  <= 1'b0;
            over_q <= 1'b0;
        end else if (cs_rise || (!csn_s_q[1] && csn_s_q[2])) begin
            got_q  <= 1'b0;
            over_q <= 1'b0;
        end else begin
            got_q  <= got_q | byte_evt;
            over_q <= over_q | over_evt;
        end
    end

    // Event and frame end may land in the same cycle; both are folded in here
    logic       frm_end;
    logic       exact;
    logic [7:0] op;

    assign frm_end = cs_rise & (got_q | byte_evt);
    assign exact   = ~(over_q | over_evt);
    assign op      = op_link_q;

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    fces_pkg::fces_state_t state_q;
    fces_pkg::fces_state_t state_d;
    fces_pkg::fces_kind_t  kind_q;
    fces_pkg::fces_kind_t  kind_d;
    logic [31:0]           cnt_q;
    logic [31:0]           cnt_d;
    logic                  write_enable_latch_q;
    logic                  accept;
    logic                  done;
    logic                  start;
    logic                  susp_go;
    logic                  res_go;

    assign done = (state_q == fces_pkg::FCES_BUSY) && (cnt_q == 32'h0000_0001);

    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        cnt_d   = cnt_q;
        accept  = 1'b0;
        start   = 1'b0;
        susp_go = 1'b0;
        res_go  = 1'b0;
        case (state_q)
            fces_pkg::FCES_IDLE: begin
                if (frm_end) begin
                    accept = (op != `FCES_OP_RESUME) && (op != `FCES_OP_SUSPEND);
                    if (is_ce(op)) begin
                        start = write_enable_latch_q && exact && (bp == 3'b000);
                        accept = start;
                        kind_d = fces_pkg::FCES_K_CE;
                        cnt_d  = CE_CYCLES;
                    end else if (is_erase(op) || is_prog(op)) begin
                        start  = write_enable_latch_q;
                        accept = start;
                        kind_d = is_prog(op) ? fces_pkg::FCES_K_PP :
                                 (op == `FCES_OP_BE32 || op == `FCES_OP_BE64) ?
                                 fces_pkg::FCES_K_BE : fces_pkg::FCES_K_SE;
                        cnt_d  = is_prog(op) ? PP_CYCLES :
                                 (op == `FCES_OP_BE32) ? BE32_CYCLES :
                                 (op == `FCES_OP_BE64) ? BE64_CYCLES : SE_CYCLES;
                    end
                    if (start) begin
                        state_d = fces_pkg::FCES_BUSY;
                    end else begin
                        kind_d = kind_q;
                        cnt_d  = cnt_q;
                    end
                end
            end
            fces_pkg::FCES_BUSY: begin
                if (done) begin
                    state_d = fces_pkg::FCES_IDLE;
                    kind_d  = fces_pkg::FCES_K_NONE;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                    if (frm_end && exact && op == `FCES_OP_SUSPEND
                        && kind_q != fces_pkg::FCES_K_CE) begin
                        susp_go = 1'b1;
                        accept  = 1'b1;
                        state_d = fces_pkg::FCES_SUSP;
                        cnt_d   = cnt_q; // Remaining time kept for the resume
                    end else if (frm_end && op == `FCES_OP_RDSR) begin
                        accept = 1'b1;
                    end
                end
            end
            fces_pkg::FCES_SUSP: begin
                if (frm_end) begin
                    if (op == `FCES_OP_RESUME) begin
                        res_go  = exact;
                        accept  = exact;
                        state_d = exact ? fces_pkg::FCES_RESUME : state_q;
                    end else if (op == `FCES_OP_WRSR || op == `FCES_OP_SUSPEND) begin
                        accept = 1'b0;
                    end else if (kind_q == fces_pkg::FCES_K_PP) begin
                        accept = !is_prog(op);
                    end else begin
                        accept = !is_erase(op);
                    end
                end
            end
            fces_pkg::FCES_RESUME: begin
                state_d = fces_pkg::FCES_BUSY;
            end
            default: begin
                state_d = fces_pkg::FCES_IDLE;
                kind_d  = fces_pkg::FCES_K_NONE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= fces_pkg::FCES_IDLE;
            kind_q  <= fces_pkg::FCES_K_NONE;
            cnt_q   <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            kind_q  <= kind_d;
            cnt_q   <= cnt_d;
        end
    end

    // Completion wins over a same-cycle enable; nothing else can race it while busy
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_enable_latch_q <= 1'b0;
        end else if (done) begin
            write_enable_latch_q <= 1'b0;
        end else if (frm_end && accept && op == `FCES_OP_WREN) begin
            write_enable_latch_q <= 1'b1;
        end else if (frm_end && accept && (op == `FCES_OP_WRDI || op == `FCES_OP_WRSR)) begin
            write_enable_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status          <= '0;
            cmd_accept      <= '0;
            array_fill      <= 1'b0;
            array_fill_byte <= `FCES_ERASED_BYTE;
        end else begin
            status.write_in_progress  <= (state_d == fces_pkg::FCES_BUSY);
            status.suspended_flag     <= (state_d == fces_pkg::FCES_SUSP);
            status.write_enable_latch <= write_enable_latch_q;
            cmd_accept.vld    <= accept;
            cmd_accept.opcode <= op;
            array_fill        <= done && kind_q == fces_pkg::FCES_K_CE;
            array_fill_byte   <= `FCES_ERASED_BYTE;
        end
    end

    always_comb begin
        stat_byte = `FCES_SR_RESET;
        stat_byte[`FCES_SR_BUSY_BIT] = status.write_in_progress;
        stat_byte[`FCES_SR_LATCH_BIT] = status.write_enable_latch;
        stat_byte[`FCES_SR_PROT_BIT +: 3] = bp;
        stat_byte[`FCES_SR_SUSP_BIT] = status.suspended_flag;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    localparam int RES_MAX = `FCES_RESUME_CYC;

    sequence s_resume_go;
        frm_end && state_q == fces_pkg::FCES_SUSP && op == `FCES_OP_RESUME && exact;
    endsequence

    sequence s_resume_done;
        !status.suspended_flag ##[1:RES_MAX] status.write_in_progress;
    endsequence

    chk_ce_start: assert property (frm_end && is_ce(op) && exact && bp == 3'b000
        && write_enable_latch_q && state_q == fces_pkg::FCES_IDLE
        |=> state_q == fces_pkg::FCES_BUSY
        && kind_q == fces_pkg::FCES_K_CE && cnt_q == CE_CYCLES ##1 status.write_in_progress)
        else $error("whole-array erase did not start");
    chk_ce_needs_latch: assert property (frm_end && is_ce(op) && !write_enable_latch_q
        && state_q == fces_pkg::FCES_IDLE |=> state_q == fces_pkg::FCES_IDLE)
        else $error("erase started without write enable");
    chk_ce_exact: assert property (frm_end && is_ce(op) && !exact
        && state_q == fces_pkg::FCES_IDLE |=> state_q == fces_pkg::FCES_IDLE)
        else $error("erase started on a long frame");
    chk_ce_protect: assert property (frm_end && is_ce(op) && bp != 3'b000
        && state_q == fces_pkg::FCES_IDLE |=> state_q == fces_pkg::FCES_IDLE)
        else $error("erase started with protection set");
    chk_done_flags: assert property (done |=> !write_enable_latch_q
        ##1 !status.write_in_progress && !status.write_enable_latch)
        else $error("flags not cleared at completion");
    chk_fill_pulse: assert property (done && kind_q == fces_pkg::FCES_K_CE
        |=> array_fill && array_fill_byte == `FCES_ERASED_BYTE ##1 !array_fill)
        else $error("array fill not issued");
    chk_ce_no_susp: assert property (state_q == fces_pkg::FCES_BUSY && !done
        && kind_q == fces_pkg::FCES_K_CE |=> state_q != fces_pkg::FCES_SUSP)
        else $error("whole-array erase was suspended");
    chk_susp_flags: assert property (susp_go |=> state_q == fces_pkg::FCES_SUSP
        && status.suspended_flag && !status.write_in_progress && $stable(cnt_q))
        else $error("suspend flags wrong");
    chk_susp_refuse: assert property (frm_end && state_q == fces_pkg::FCES_SUSP
        && (op == `FCES_OP_WRSR || (kind_q != fces_pkg::FCES_K_PP && is_erase(op)))
        |=> !cmd_accept.vld)
        else $error("refused opcode accepted in erase suspend");
    chk_psusp_refuse: assert property (frm_end && state_q == fces_pkg::FCES_SUSP
        && kind_q == fces_pkg::FCES_K_PP && is_prog(op) |=> !cmd_accept.vld)
        else $error("program accepted in program suspend");
    chk_resume_seq: assert property (s_resume_go |=> s_resume_done)
        else $error("resume did not restart the operation");
    chk_resume_ign: assert property (frm_end && op == `FCES_OP_RESUME
        && state_q != fces_pkg::FCES_SUSP |=> !cmd_accept.vld && !$rose(status.suspended_flag))
        else $error("resume not ignored");

endmodule : fces_seq

// ### include/fces_regs.svh
// Opcodes, status bit positions, reset values and timing counts of the erase sequencer
`ifndef FCES_REGS_SVH
`define FCES_REGS_SVH

`define FCES_OP_WREN        8'h06
`define FCES_OP_WRDI        8'h04
`define FCES_OP_RDSR        8'h05
`define FCES_OP_WRSR        8'h01
`define FCES_OP_PP          8'h02
`define FCES_OP_PP_ALT      8'h42
`define FCES_OP_QPP         8'h32
`define FCES_OP_SE          8'h20
`define FCES_OP_BE32        8'h52
`define FCES_OP_BE64        8'hD8
`define FCES_OP_SECR_ER     8'h44
`define FCES_OP_CE_A        8'hC7
`define FCES_OP_CE_B        8'h60
`define FCES_OP_SUSPEND     8'h75
`define FCES_OP_RESUME      8'h7A

`define FCES_SR_BUSY_BIT    0
`define FCES_SR_LATCH_BIT   1
`define FCES_SR_PROT_BIT    2
`define FCES_SR_SUSP_BIT    7
`define FCES_SR_RESET       8'h00
`define FCES_ERASED_BYTE    8'hFF

`define FCES_CLK_MHZ        100
`define FCES_CYC_PER_MS     (`FCES_CLK_MHZ * 1000)
`define FCES_T_CE_MS        25000
`define FCES_T_PP_US        600
`define FCES_T_SE_MS        50
`define FCES_T_BE32_MS      150
`define FCES_T_BE64_MS      250
`define FCES_T_RESUME_NS    200
`define FCES_CE_CYC         32'(64'(`FCES_T_CE_MS) * 64'(`FCES_CYC_PER_MS))
`define FCES_PP_CYC         32'(`FCES_T_PP_US * `FCES_CLK_MHZ)
`define FCES_SE_CYC         32'(`FCES_T_SE_MS * `FCES_CYC_PER_MS)
`define FCES_BE32_CYC       32'(`FCES_T_BE32_MS * `FCES_CYC_PER_MS)
`define FCES_BE64_CYC       32'(`FCES_T_BE64_MS * `FCES_CYC_PER_MS)
`define FCES_RESUME_CYC     ((`FCES_T_RESUME_NS * `FCES_CLK_MHZ) / 1000)

`endif

// ### include/fces_pkg.sv
// Types shared by the erase / suspend / resume sequencer
package fces_pkg;

    typedef enum logic [1:0] {
        FCES_IDLE   = 2'b00,
        FCES_BUSY   = 2'b01,
        FCES_SUSP   = 2'b11,
        FCES_RESUME = 2'b10
    } fces_state_t;

    typedef enum logic [2:0] {
        FCES_K_NONE = 3'd0,
        FCES_K_PP   = 3'd1,
        FCES_K_SE   = 3'd2,
        FCES_K_BE   = 3'd3,
        FCES_K_CE   = 3'd4
    } fces_kind_t;

    typedef struct packed {
        logic suspended_flag;
        logic write_enable_latch;
        logic write_in_progress;
    } fces_status_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] opcode;
    } fces_cmd_t;

endpackage : fces_pkg

// ### tb/fces_host_model.sv
// SPI host controller model that frames opcodes for the erase sequencer
`timescale 1ns/1ps

module fces_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe
);
    // Link clock stands low between frames; it is made only inside frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b1;
    end

    // ------------------------------------------------------------
    // One frame: opcode MSB first, then zero bits up to nbits
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] op, input int nbits, output logic [7:0] rd);
        logic b;
        rd = 8'h00;
        #5;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            b  = (i < 8) ? op[7 - i] : 1'b0;
            si = b;
            #16 sclk = 1'b1;
            if (i >= 8 && i < 16 && so_oe === 1'b1) rd = {rd[6:0], so_out};
            #16 sclk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // Released line must not keep showing the last bit
        si = ~si;
        #40;
    endtask : frame
endmodule : fces_host_model

// ### tb/tb.sv
// Self-checking bench of the erase, suspend and resume sequencer
`timescale 1ns/1ps
`include "fces_regs.svh"

module tb;
    typedef struct {
        logic       wren;
        logic [7:0] op;
        int         nbits;
        logic [2:0] bp;
        logic       exp_acc;
    } fces_row_t;

    logic                   clk_sys;
    logic                   rst;
    logic                   sclk;
    logic                   cs_n;
    logic                   si;
    logic                   so_out;
    logic                   so_oe;
    logic [2:0]             bp;
    fces_pkg::fces_status_t status;
    fces_pkg::fces_cmd_t    cmd_accept;
    logic                   array_fill;
    logic [7:0]             array_fill_byte;
    logic [7:0]             rd;
    logic [7:0]             acc_op;
    int                     err_total;
    int                     checks_done;
    int                     acc_n;
    int                     fill_n;

    fces_row_t rows [9] = '{
        '{1'b1, `FCES_OP_CE_A, 8, 3'b000, 1'b1},
        '{1'b1, `FCES_OP_CE_B, 8, 3'b000, 1'b1},
        '{1'b0, `FCES_OP_CE_A, 8, 3'b000, 1'b0},
        '{1'b1, `FCES_OP_CE_A, 9, 3'b000, 1'b0},
        '{1'b1, `FCES_OP_CE_B, 7, 3'b000, 1'b0},
        '{1'b1, `FCES_OP_CE_A, 8, 3'b100, 1'b0},
        '{1'b1, `FCES_OP_CE_B, 8, 3'b001, 1'b0},
        '{1'b0, `FCES_OP_RESUME, 8, 3'b000, 1'b0},
        '{1'b0, `FCES_OP_SUSPEND, 8, 3'b000, 1'b0}
    };

    fces_seq #(
        .CE_CYCLES   (32'd150),
        .PP_CYCLES   (32'd200),
        .SE_CYCLES   (32'd200),
        .BE32_CYCLES (32'd200),
        .BE64_CYCLES (32'd200)
    ) dut (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .sclk            (sclk),
        .cs_n            (cs_n),
        .si              (si),
        .so_out          (so_out),
        .so_oe           (so_oe),
        .protect_bit_0   (bp[0]),
        .protect_bit_1   (bp[1]),
        .protect_bit_2   (bp[2]),
        .status          (status),
        .cmd_accept      (cmd_accept),
        .array_fill      (array_fill),
        .array_fill_byte (array_fill_byte)
    );

    fces_host_model host (
        .sclk   (sclk),
        .cs_n   (cs_n),
        .si     (si),
        .so_out (so_out),
        .so_oe  (so_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Pulses are one cycle wide, so they are counted rather than polled
    always @(posedge clk_sys) begin
        if (cmd_accept.vld === 1'b1) begin
            acc_n  = acc_n + 1;
            acc_op = cmd_accept.opcode;
        end
        if (array_fill === 1'b1) fill_n = fill_n + 1;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic send(input logic [7:0] op, input int nbits);
        @(negedge clk_sys);
        acc_n  = 0;
        fill_n = 0;
        host.frame(op, nbits, rd);
        repeat (10) @(negedge clk_sys);
    endtask : send

    task automatic wait_idle();
        for (int i = 0; i < 400 && status.write_in_progress !== 1'b0; i++) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
    endtask : wait_idle

    // Runs an operation, suspends it, probes refused and allowed opcodes, resumes
    task automatic susp_case(input logic [7:0] start_op, input logic [7:0] refl [$],
                             input logic [7:0] ok_op);
        send(`FCES_OP_WREN, 8);
        send(start_op, 32);
        send(`FCES_OP_RESUME, 8);
        chk("resume while busy", 8'h00, 8'(acc_n));
        send(`FCES_OP_SUSPEND, 8);
        chk("suspend taken", 8'h01, 8'(acc_n));
        // Latch stays set through suspend; completion, an accepted write disable or status write clears it
        chk("status in suspend", 8'h06, {5'h00, status});
        send(`FCES_OP_WREN, 8);
        foreach (refl[k]) begin
            send(refl[k], (refl[k] == `FCES_OP_CE_A || refl[k] == `FCES_OP_CE_B) ? 8 : 32);
            chk("refused in suspend", 8'h00, 8'(acc_n));
        end
        send(ok_op, 32);
        chk("allowed in suspend", ok_op, (acc_n == 1) ? acc_op : 8'h00);
        send(`FCES_OP_RESUME, 8);
        chk("resume taken", 8'h01, 8'(acc_n));
        chk("status after resume", 8'h00, 8'(status.suspended_flag));
        chk("busy after resume", 8'h01, 8'(status.write_in_progress));
        wait_idle();
        chk("resumed op done", 8'h00, 8'(status.write_in_progress));
        $display("suspend case %h done", start_op);
    endtask : susp_case

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    initial begin
        #300000;
        err_total++;
        give_verdict();
    end

    initial begin
        err_total   = 0;
        checks_done = 0;
        acc_n       = 0;
        fill_n      = 0;
        acc_op      = 8'h00;
        bp          = 3'b000;
        rst         = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk("status in reset", 8'h00, {5'h00, status});
        chk("fill byte", `FCES_ERASED_BYTE, array_fill_byte);
        chk("so enable in reset", 8'h00, {7'h00, so_oe});
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        $display("reset test done");

        foreach (rows[i]) begin
            bp = rows[i].bp;
            if (rows[i].wren) send(`FCES_OP_WREN, 8);
            send(rows[i].op, rows[i].nbits);
            chk("accepted", 8'(rows[i].exp_acc), 8'(acc_n));
            chk("busy", 8'(rows[i].exp_acc), 8'(status.write_in_progress));
            if (rows[i].exp_acc) begin
                wait_idle();
                chk("idle after erase", 8'h00, {5'h00, status});
                chk("fill pulses", 8'h01, 8'(fill_n));
            end
            $display("row %0d done", i);
        end
        bp = 3'b000;

        send(`FCES_OP_WREN, 8);
        send(`FCES_OP_CE_A, 8);
        send(`FCES_OP_RDSR, 16);
        chk("status byte busy", 8'h03, rd);
        send(`FCES_OP_SUSPEND, 8);
        chk("suspend in chip erase", 8'h00, 8'(acc_n));
        chk("no suspend flag", 8'h00, 8'(status.suspended_flag));
        wait_idle();
        send(`FCES_OP_RDSR, 16);
        chk("status byte idle", 8'h00, rd);
        $display("chip erase status test done");

        susp_case(`FCES_OP_SE, '{`FCES_OP_WRSR, `FCES_OP_SE, `FCES_OP_BE64, `FCES_OP_CE_A,
                  `FCES_OP_CE_B, `FCES_OP_SECR_ER, `FCES_OP_BE32}, `FCES_OP_PP);
        susp_case(`FCES_OP_PP, '{`FCES_OP_WRSR, `FCES_OP_PP, `FCES_OP_PP_ALT}, `FCES_OP_SE);

        // Reset in mid erase must drop every status bit
        send(`FCES_OP_WREN, 8);
        send(`FCES_OP_CE_B, 8);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("status after mid reset", 8'h00, {5'h00, status});
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        $display("mid reset test done");
        give_verdict();
    end
endmodule : tb
